// [dmtc_pkg.sv]
package dmtc_pkg;
   localparam logic [7:0] ADDR_TMC = 8'h89;
   localparam logic [7:0] ADDR_T01C = 8'h88;
   localparam logic [7:0] ADDR_TL0 = 8'h8A;
   localparam logic [7:0] ADDR_TL1 = 8'h8B;
   localparam logic [7:0] ADDR_TH0 = 8'h8C;
   localparam logic [7:0] ADDR_TH1 = 8'h8D;
   localparam logic [7:0] ADDR_T2C = 8'hC8;
   localparam logic [7:0] ADDR_TL2 = 8'hCC;
   localparam logic [7:0] ADDR_TH2 = 8'hCD;
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam int CYC_CLKS = 12;
   localparam logic [3:0] PH_SAMPLE = 4'h9;
   localparam logic [3:0] PH_UPDATE = 4'h4;
   localparam logic [3:0] PH_LAST = 4'hB;
   localparam logic [1:0] M_PRESC = 2'h0;
   localparam logic [1:0] M_16 = 2'h1;
   localparam logic [1:0] M_RELOAD = 2'h2;
   localparam logic [1:0] M_SPLIT = 2'h3;
   localparam logic [4:0] PRESC_MAX = 5'h1F;
   localparam int RUN0_BIT = 4;
   localparam int RUN1_BIT = 6;
   localparam int RUN2_BIT = 2;
   localparam int SRC2_BIT = 1;
   typedef struct packed {
      logic gate;
      logic ext_src;
      logic [1:0] mode;
   } dmtc_cfg_t;
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } dmtc_sfr_t;
endpackage

// [dmtc_edge.sv]
`timescale 1ns/1ps
`default_nettype none
module dmtc_edge (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic pin,
   input wire logic sample,
   output logic fell
);
   logic s1_q;
   logic s2_q;
   logic prev_q;
   logic hit_q;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
      end else begin
         s1_q <= pin;
         s2_q <= s1_q;
      end
   end
   // sample once per machine cycle, flag high then low
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         prev_q <= 1'b0;
         hit_q <= 1'b0;
      end else if (sample) begin
         prev_q <= s2_q;
         hit_q <= prev_q & ~s2_q;
      end
   end
   assign fell = hit_q;
endmodule // dmtc_edge
`default_nettype wire

// [dmtc_top.sv]
`timescale 1ns/1ps
`default_nettype none
module dmtc_top (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic sync_clear,
   input wire dmtc_pkg::dmtc_sfr_t sfr,
   output logic [7:0] sfr_rdata,
   input wire logic count_pin_0,
   input wire logic count_pin_1,
   input wire logic count_pin_2,
   input wire logic ext_irq_pin_0,
   input wire logic ext_irq_pin_1,
   output logic [2:0] overflow
);
   // --------------------------------------------------------------
   // reset and machine cycle
   // --------------------------------------------------------------
   logic r1_q;
   logic rst_n;
   logic [3:0] ph_q;
   logic upd;
   logic smp;
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         r1_q <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         r1_q <= 1'b1;
         rst_n <= r1_q;
      end
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) ph_q <= 4'h0;
      else if (ph_q == dmtc_pkg::PH_LAST) ph_q <= 4'h0;
      else ph_q <= ph_q + 4'h1;
   end
   assign smp = (ph_q == dmtc_pkg::PH_SAMPLE);
   // counts land at state3_phase1 of the cycle after detection
   assign upd = (ph_q == dmtc_pkg::PH_UPDATE);
   // --------------------------------------------------------------
   // pins
   // --------------------------------------------------------------
   logic [2:0] fell;
   logic g1_q;
   logic g1s_q;
   logic g0_q;
   logic g0s_q;
   dmtc_edge u_e0 (.clk(clk), .rst_n(rst_n), .pin(count_pin_0), .sample(smp), .fell(fell[0]));
   dmtc_edge u_e1 (.clk(clk), .rst_n(rst_n), .pin(count_pin_1), .sample(smp), .fell(fell[1]));
   dmtc_edge u_e2 (.clk(clk), .rst_n(rst_n), .pin(count_pin_2), .sample(smp), .fell(fell[2]));
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         g0_q <= 1'b0;
         g0s_q <= 1'b0;
         g1_q <= 1'b0;
         g1s_q <= 1'b0;
      end else begin
         g0_q <= ext_irq_pin_0;
         g0s_q <= g0_q;
         g1_q <= ext_irq_pin_1;
         g1s_q <= g1_q;
      end
   end
   // --------------------------------------------------------------
   // registers
   // --------------------------------------------------------------
   logic [7:0] tmc_q;
   logic [7:0] t01c_q;
   logic [7:0] t2c_q;
   logic [7:0] tl_q [3];
   logic [7:0] th_q [3];
   dmtc_pkg::dmtc_cfg_t cfg0;
   dmtc_pkg::dmtc_cfg_t cfg1;
   assign cfg0 = tmc_q[3:0];
   assign cfg1 = tmc_q[7:4];
   // whole-byte access only
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) tmc_q <= dmtc_pkg::RST_BYTE;
      else if (sfr.wr && sfr.addr == dmtc_pkg::ADDR_TMC) tmc_q <= sfr.wdata;
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         t01c_q <= dmtc_pkg::RST_BYTE;
         t2c_q <= dmtc_pkg::RST_BYTE;
      end else if (sync_clear) begin
         t01c_q <= dmtc_pkg::RST_BYTE;
         t2c_q <= dmtc_pkg::RST_BYTE;
      end else begin
         if (sfr.wr && sfr.addr == dmtc_pkg::ADDR_T01C) t01c_q <= sfr.wdata;
         if (sfr.wr && sfr.addr == dmtc_pkg::ADDR_T2C) t2c_q <= sfr.wdata;
      end
   end
   // --------------------------------------------------------------
   // count enables
   // --------------------------------------------------------------
   function automatic logic tick(input logic ext, input logic f);
      tick = upd && (ext ? f : 1'b1);
   endfunction
   logic run0;
   logic run1;
   logic en0;
   logic en1;
   logic en2;
   logic en0h;
   // gate needs the irq pin high as well as the run bit
   assign run0 = t01c_q[dmtc_pkg::RUN0_BIT] & (~cfg0.gate | g0s_q);
   assign run1 = t01c_q[dmtc_pkg::RUN1_BIT] & (~cfg1.gate | g1s_q);
   assign en0 = run0 & tick(cfg0.ext_src, fell[0]);
   assign en1 = run1 & tick(cfg1.ext_src, fell[1]) & (cfg1.mode != dmtc_pkg::M_SPLIT);
   // split high byte of timer 0 is a timer run by timer 1 run bit
   assign en0h = t01c_q[dmtc_pkg::RUN1_BIT] & upd;
   assign en2 = t2c_q[dmtc_pkg::RUN2_BIT] & tick(t2c_q[dmtc_pkg::SRC2_BIT], fell[2]);
   logic [2:0] en;
   logic [2:0] ovf;
   logic [1:0] md [3];
   assign en = {en2, en1, en0};
   assign md[0] = cfg0.mode;
   assign md[1] = cfg1.mode;
   assign md[2] = dmtc_pkg::M_16;
   // --------------------------------------------------------------
   // counters
   // --------------------------------------------------------------
   logic [2:0] wtl;
   logic [2:0] wth;
   assign wtl[0] = sfr.wr && sfr.addr == dmtc_pkg::ADDR_TL0;
   assign wtl[1] = sfr.wr && sfr.addr == dmtc_pkg::ADDR_TL1;
   assign wtl[2] = sfr.wr && sfr.addr == dmtc_pkg::ADDR_TL2;
   assign wth[0] = sfr.wr && sfr.addr == dmtc_pkg::ADDR_TH0;
   assign wth[1] = sfr.wr && sfr.addr == dmtc_pkg::ADDR_TH1;
   assign wth[2] = sfr.wr && sfr.addr == dmtc_pkg::ADDR_TH2;
   for (genvar i = 0; i < 3; i++) begin : g_cnt
      logic lo_wrap;
      logic hi_inc;
      logic hi_wrap;
      logic split_h;
      assign split_h = (i == 0) && md[i] == dmtc_pkg::M_SPLIT;
      always_comb begin
         lo_wrap = 1'b0;
         hi_inc = 1'b0;
         unique case (md[i])
            dmtc_pkg::M_PRESC: begin
               lo_wrap = tl_q[i][4:0] == dmtc_pkg::PRESC_MAX;
               hi_inc = en[i] & lo_wrap;
            end
            dmtc_pkg::M_16: begin
               lo_wrap = tl_q[i] == 8'hFF;
               hi_inc = en[i] & lo_wrap;
            end
            dmtc_pkg::M_RELOAD: lo_wrap = tl_q[i] == 8'hFF;
            dmtc_pkg::M_SPLIT: begin
               lo_wrap = tl_q[i] == 8'hFF;
               hi_inc = en0h & (i == 0);
            end
         endcase
      end
      assign hi_wrap = hi_inc & (th_q[i] == 8'hFF);
      always_ff @(posedge clk or negedge rst_n) begin
         if (!rst_n) tl_q[i] <= dmtc_pkg::RST_BYTE;
         else if (sync_clear) tl_q[i] <= dmtc_pkg::RST_BYTE;
         else if (wtl[i]) tl_q[i] <= sfr.wdata;
         else if (en[i]) begin
            if (md[i] == dmtc_pkg::M_RELOAD && lo_wrap) tl_q[i] <= th_q[i];
            else if (md[i] == dmtc_pkg::M_PRESC && lo_wrap) tl_q[i] <= {tl_q[i][7:5], 5'h00};
            else tl_q[i] <= tl_q[i] + 8'h01;
         end
      end
      always_ff @(posedge clk or negedge rst_n) begin
         if (!rst_n) th_q[i] <= dmtc_pkg::RST_BYTE;
         else if (sync_clear) th_q[i] <= dmtc_pkg::RST_BYTE;
         else if (wth[i]) th_q[i] <= sfr.wdata;
         else if (hi_inc) th_q[i] <= th_q[i] + 8'h01;
      end
      always_comb begin
         if (md[i] == dmtc_pkg::M_PRESC || md[i] == dmtc_pkg::M_16) ovf[i] = hi_wrap;
         else ovf[i] = en[i] & lo_wrap & ~split_h | (split_h & 1'b0);
      end
   end
   // split mode: high byte overflow of timer 0 reports as timer 1
   logic [2:0] ovf_q;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) ovf_q <= 3'h0;
      else if (md[0] == dmtc_pkg::M_SPLIT)
         ovf_q <= {ovf[2], g_cnt[0].hi_wrap, en0 & (tl_q[0] == 8'hFF)};
      else ovf_q <= ovf;
   end
   assign overflow = ovf_q;
   // --------------------------------------------------------------
   // read port
   // --------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) sfr_rdata <= dmtc_pkg::RST_BYTE;
      else if (sfr.rd) begin
         unique case (sfr.addr)
            dmtc_pkg::ADDR_TMC: sfr_rdata <= tmc_q;
            dmtc_pkg::ADDR_T01C: sfr_rdata <= t01c_q;
            dmtc_pkg::ADDR_T2C: sfr_rdata <= t2c_q;
            dmtc_pkg::ADDR_TL0: sfr_rdata <= tl_q[0];
            dmtc_pkg::ADDR_TL1: sfr_rdata <= tl_q[1];
            dmtc_pkg::ADDR_TL2: sfr_rdata <= tl_q[2];
            dmtc_pkg::ADDR_TH0: sfr_rdata <= th_q[0];
            dmtc_pkg::ADDR_TH1: sfr_rdata <= th_q[1];
            dmtc_pkg::ADDR_TH2: sfr_rdata <= th_q[2];
            default: sfr_rdata <= dmtc_pkg::RST_BYTE;
         endcase
      end
   end
   // --------------------------------------------------------------
   // checks
   // --------------------------------------------------------------
   property p_mcycle;
      @(posedge clk) disable iff (!rst_n) upd |-> ##12 upd;
   endproperty
   a_mcycle: assert property (p_mcycle) else $error("machine cycle not 12 clocks");
   property p_timer_inc;
      @(posedge clk) disable iff (!rst_n)
         (en0 && !cfg0.ext_src && md[0] == dmtc_pkg::M_16 && !wtl[0] && !sync_clear
          && tl_q[0] != 8'hFF) |=> tl_q[0] == $past(tl_q[0]) + 8'h01;
   endproperty
   a_timer_inc: assert property (p_timer_inc) else $error("timer low byte not advanced");
   property p_upd_phase;
      @(posedge clk) disable iff (!rst_n) (en[0] || en[1] || en[2]) |-> upd;
   endproperty
   a_upd_phase: assert property (p_upd_phase) else $error("count outside update phase");
   // clocks since the last pin sample, saturating
   logic [3:0] gap_q;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) gap_q <= '1;
      else if (smp) gap_q <= '0;
      else if (gap_q != '1) gap_q <= gap_q + 4'h1;
   end
   property p_sample_gap;
      @(posedge clk) disable iff (!rst_n) smp |-> gap_q >= dmtc_pkg::PH_LAST;
   endproperty
   a_sample_gap: assert property (p_sample_gap) else $error("pin sampled too often");
   // flagged edge must be applied at the next update phase
   sequence s_flag0;
      $rose(fell[0]) && cfg0.ext_src;
   endsequence
   sequence s_land0;
      upd && fell[0];
   endsequence
   property p_edge_lands;
      @(posedge clk) disable iff (!rst_n) s_flag0 |-> ##6 s_land0;
   endproperty
   a_edge_lands: assert property (p_edge_lands) else $error("pin edge missed its slot");
   property p_mode_reset;
      @(posedge clk) $rose(rst_n) |-> tmc_q == dmtc_pkg::RST_BYTE;
   endproperty
   a_mode_reset: assert property (p_mode_reset) else $error("mode register not reset");
   property p_sclr;
      @(posedge clk) disable iff (!rst_n) sync_clear |=> tl_q[1] == 8'h00 && th_q[1] == 8'h00
         && t01c_q == 8'h00;
   endproperty
   a_sclr: assert property (p_sclr) else $error("sync clear failed");
   property p_gate;
      @(posedge clk) disable iff (!rst_n) (cfg1.gate && !g1s_q) |-> !en1;
   endproperty
   a_gate: assert property (p_gate) else $error("gated timer counted");
   property p_reload;
      @(posedge clk) disable iff (!rst_n)
         (en1 && md[1] == dmtc_pkg::M_RELOAD && tl_q[1] == 8'hFF && !wtl[1] && !sync_clear)
         |=> tl_q[1] == $past(th_q[1]);
   endproperty
   a_reload: assert property (p_reload) else $error("reload value not loaded");
   property p_stop1;
      @(posedge clk) disable iff (!rst_n) md[1] == dmtc_pkg::M_SPLIT |-> !en1;
   endproperty
   a_stop1: assert property (p_stop1) else $error("timer 1 ran in stop mode");
endmodule // dmtc_top
`default_nettype wire

// [dmtc_pulse_src.sv]
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// external event source for the count pins
// ----------------------------------------
module dmtc_pulse_src (
   input wire logic clk,
   output logic [2:0] pins
);
   // pins idle high, as with a pull-up
   initial pins = 3'h7;

   // n falling edges, each level held for hold clocks
   task automatic burst(input int sel, input int n, input int hold);
      for (int i = 0; i < n; i++) begin
         @(posedge clk) pins[sel] <= 1'b0;
         repeat (hold - 1) @(posedge clk);
         @(posedge clk) pins[sel] <= 1'b1;
         repeat (hold - 1) @(posedge clk);
      end
   endtask
endmodule // dmtc_pulse_src
`default_nettype wire

// [dmtc_bench.sv]
`timescale 1ns/1ps
`default_nettype none
module dmtc_bench;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic sync_clear = 1'b0;
   dmtc_pkg::dmtc_sfr_t sfr = '0;
   logic [7:0] sfr_rdata;
   logic [2:0] pins;
   logic [1:0] irq = 2'h0;
   logic [2:0] overflow;
   logic [2:0] ov_seen = 3'h0;
   logic [7:0] rd_v;
   logic [7:0] regs [10] = '{8'h89, 8'h88, 8'h8A, 8'h8B, 8'h8C, 8'h8D, 8'hC8, 8'hCC, 8'hCD,
                             8'h8E};
   int err_count = 0;
   int n_compared = 0;
   int cycles = 0;

   always #4 clk = ~clk;

   dmtc_top i_dmtc_top (.clk(clk), .rst_b(rst_b), .sync_clear(sync_clear), .sfr(sfr),
      .sfr_rdata(sfr_rdata), .count_pin_0(pins[0]), .count_pin_1(pins[1]),
      .count_pin_2(pins[2]), .ext_irq_pin_0(irq[0]), .ext_irq_pin_1(irq[1]),
      .overflow(overflow));
   dmtc_pulse_src i_dmtc_pulse_src (.clk(clk), .pins(pins));

   always @(posedge clk) begin
      if (!rst_b) ov_seen <= 3'h0;
      else ov_seen <= ov_seen | overflow;
      cycles++;
      if (cycles == 20000) begin
         err_count++;
         summarize();
      end
   end

   // ----------------------------------------
   // access tasks
   // ----------------------------------------
   task automatic summarize();
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         err_count++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk) sfr <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge clk) sfr <= '0;
   endtask

   task automatic rchk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
      @(posedge clk) sfr <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(posedge clk) sfr <= '0;
      @(negedge clk) rd_v = sfr_rdata;
      chk(rd_v & m, e);
   endtask

   // run bits on for exactly 120 clocks: ten machine cycles
   task automatic run_win(input logic [7:0] a, input logic [7:0] on);
      wr(a, on);
      repeat (118) @(posedge clk);
      wr(a, 8'h00);
   endtask

   // ----------------------------------------
   // test sequence
   // ----------------------------------------
   initial begin
      repeat (16) @(posedge clk);
      rst_b <= 1'b1;
      repeat (4) @(posedge clk);
      foreach (regs[i]) rchk(regs[i], 8'hFF, 8'h00);
      wr(dmtc_pkg::ADDR_TMC, 8'hA5);
      rchk(dmtc_pkg::ADDR_TMC, 8'hFF, 8'hA5);
      wr(dmtc_pkg::ADDR_TMC, 8'h01);
      wr(dmtc_pkg::ADDR_TL0, 8'hFB);
      wr(dmtc_pkg::ADDR_TH0, 8'h00);
      run_win(dmtc_pkg::ADDR_T01C, 8'h10);
      rchk(dmtc_pkg::ADDR_TL0, 8'hFF, 8'h05);
      rchk(dmtc_pkg::ADDR_TH0, 8'hFF, 8'h01);
      wr(dmtc_pkg::ADDR_TMC, 8'h09);
      wr(dmtc_pkg::ADDR_TL0, 8'h00);
      run_win(dmtc_pkg::ADDR_T01C, 8'h10);
      rchk(dmtc_pkg::ADDR_TL0, 8'hFF, 8'h00);
      @(posedge clk) irq <= 2'h3;
      repeat (4) @(posedge clk);
      run_win(dmtc_pkg::ADDR_T01C, 8'h10);
      rchk(dmtc_pkg::ADDR_TL0, 8'hFF, 8'h0A);
      wr(dmtc_pkg::ADDR_TMC, 8'h00);
      wr(dmtc_pkg::ADDR_TL0, 8'h1C);
      wr(dmtc_pkg::ADDR_TH0, 8'h05);
      run_win(dmtc_pkg::ADDR_T01C, 8'h10);
      rchk(dmtc_pkg::ADDR_TL0, 8'h1F, 8'h06);
      rchk(dmtc_pkg::ADDR_TH0, 8'hFF, 8'h06);
      wr(dmtc_pkg::ADDR_TMC, 8'h20);
      wr(dmtc_pkg::ADDR_TL1, 8'hFC);
      wr(dmtc_pkg::ADDR_TH1, 8'h80);
      run_win(dmtc_pkg::ADDR_T01C, 8'h40);
      rchk(dmtc_pkg::ADDR_TL1, 8'hFF, 8'h86);
      rchk(dmtc_pkg::ADDR_TH1, 8'hFF, 8'h80);
      chk({5'h00, ov_seen}, 8'h02);
      wr(dmtc_pkg::ADDR_TMC, 8'h33);
      wr(dmtc_pkg::ADDR_TL0, 8'h00);
      wr(dmtc_pkg::ADDR_TH0, 8'h00);
      wr(dmtc_pkg::ADDR_TL1, 8'h00);
      run_win(dmtc_pkg::ADDR_T01C, 8'h50);
      rchk(dmtc_pkg::ADDR_TL0, 8'hFF, 8'h0A);
      rchk(dmtc_pkg::ADDR_TH0, 8'hFF, 8'h0A);
      rchk(dmtc_pkg::ADDR_TL1, 8'hFF, 8'h00);
      wr(dmtc_pkg::ADDR_TMC, 8'h55);
      wr(dmtc_pkg::ADDR_TL0, 8'h00);
      wr(dmtc_pkg::ADDR_TH0, 8'h00);
      wr(dmtc_pkg::ADDR_T01C, 8'h50);
      i_dmtc_pulse_src.burst(0, 5, 12);
      i_dmtc_pulse_src.burst(1, 3, 12);
      repeat (48) @(posedge clk);
      wr(dmtc_pkg::ADDR_T01C, 8'h00);
      rchk(dmtc_pkg::ADDR_TL0, 8'hFF, 8'h05);
      rchk(dmtc_pkg::ADDR_TL1, 8'hFF, 8'h03);
      wr(dmtc_pkg::ADDR_TL2, 8'hFE);
      wr(dmtc_pkg::ADDR_TH2, 8'hFF);
      wr(dmtc_pkg::ADDR_T2C, 8'h06);
      i_dmtc_pulse_src.burst(2, 3, 12);
      repeat (48) @(posedge clk);
      wr(dmtc_pkg::ADDR_T2C, 8'h00);
      rchk(dmtc_pkg::ADDR_TL2, 8'hFF, 8'h01);
      rchk(dmtc_pkg::ADDR_TH2, 8'hFF, 8'h00);
      run_win(dmtc_pkg::ADDR_T2C, 8'h04);
      rchk(dmtc_pkg::ADDR_TL2, 8'hFF, 8'h0B);
      wr(dmtc_pkg::ADDR_TMC, 8'h01);
      wr(dmtc_pkg::ADDR_T01C, 8'h10);
      @(posedge clk) sync_clear <= 1'b1;
      @(posedge clk) sync_clear <= 1'b0;
      rchk(dmtc_pkg::ADDR_TL2, 8'hFF, 8'h00);
      rchk(dmtc_pkg::ADDR_T01C, 8'hFF, 8'h00);
      repeat (120) @(posedge clk);
      rchk(dmtc_pkg::ADDR_TL0, 8'hFF, 8'h00);
      summarize();
   end
endmodule // dmtc_bench
`default_nettype wire
